// File: include/osdcd_defs.svh
// Behaviour
// - Commands decode in the bank chosen by two bank flags; reset clears both.
// - Bank 01 nibble 0101 loads sync polarities and two-bit display mode.
// - Sync polarity 0 means active low (default), 1 active high.
// - Mode 00 overlays character dots on video without background.
// - Mode 01 draws north-west shadows only for 2x and 4x sizes.
// - Mode 10 paints a 12 by 18 background cell behind characters.
// - Mode 11 fills all non-dot area with frame colour, default blue.
// - Bank 01 nibble 0110 loads blink frequency and blink duty.
// - Blink period is vsync divided by 16, 32, 64 or 128.
// - Blink duty 3:1, 1:1, 1:3; code 11 reserved for host.
// - Bank 01 0111_0x00 selects shared pin: port data or monitor.
// - Bank 01 nibbles 1001, 1010, 1011 assemble 6-bit start positions.
// - First character 4*H+5 clocks after hsync; host keeps H at least 4.
// - Display starts 4*V scan lines after vsync; any V valid.
// - Bank 01 bits 7:6 equal 11 write port data from bits 4, 1, 0.
// - Bank 00 nibble 0100 loads frame background colour RGBI.
// - Bank 00 nibble 0101 loads misc bits; bit 3 enables stabilization.
// - Half-tone defaults off and acts only while monitor bit is 1.
// - Misc bits 1:0 give character size of the first display row.
// - First-row size 00 single, 01 double, 10 triple, 11 quadruple.
`ifndef OSDCD_DEFS_SVH
`define OSDCD_DEFS_SVH

// ---------------------------------------------------------------
// Command patterns
// ---------------------------------------------------------------
`define OSDCD_BANK_00        2'h0
`define OSDCD_BANK_01        2'h1
`define OSDCD_OP_BANK        6'h1e
`define OSDCD_OP_SYNC_MODE   4'h5
`define OSDCD_OP_BLINK       4'h6
`define OSDCD_OP_PINFUNC     4'h7
`define OSDCD_OP_VSTART      4'h9
`define OSDCD_OP_VH_START    4'ha
`define OSDCD_OP_HSTART      4'hb
`define OSDCD_OP_PORT        2'h3
`define OSDCD_OP_FRAME_COL   4'h4
`define OSDCD_OP_MISC        4'h5

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define OSDCD_PINFUNC_BIT    2
`define OSDCD_PORT_SHARED    4
`define OSDCD_HSTAB_BIT      3
`define OSDCD_HTONE_BIT      2
`define OSDCD_RST_SYNC_MODE  4'h0
`define OSDCD_RST_BLINK      4'h0
`define OSDCD_RST_FRAME_COL  4'h2
`define OSDCD_RST_MISC       4'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define OSDCD_CLK_PERIOD_NS  5
`define OSDCD_HSTART_MUL     4
`define OSDCD_HSTART_ADD     5
`define OSDCD_VSTART_MUL     4
`define OSDCD_BLINK_BASE     16

`endif

// File: include/osdcd_pkg.sv
package osdcd_pkg;

  typedef enum logic [1:0] {
    MODE_PLAIN  = 2'h0,
    MODE_NWSHAD = 2'h1,
    MODE_BOX    = 2'h2,
    MODE_FRAME  = 2'h3
  } osdcd_mode_type;

  typedef enum logic [2:0] {
    H_WAIT  = 3'h1,
    H_COUNT = 3'h2,
    H_SHOW  = 3'h4
  } osdcd_hstate_type;

endpackage : osdcd_pkg

// File: logic/osdcd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "osdcd_defs.svh"

module osdcd_decoder
  import osdcd_pkg::*;
(
  input  wire logic       clk,             // Display clock
  input  wire logic       rst,             // Master reset
  input  wire logic [7:0] cmdByte,         // Received command byte
  input  wire logic       cmdValid,        // Byte strobe
  input  wire logic       hsyncPin,        // Raw horizontal sync
  input  wire logic       vsyncPin,        // Raw vertical sync
  input  wire logic       charDot,         // Character dot lit
  input  wire logic       shadowDot,       // North-west shadow dot
  input  wire logic       inCell,          // Inside a character cell
  input  wire logic       acmBit,          // Monitor attribute bit
  input  wire logic [3:0] fgColour,        // Character colour
  input  wire logic [3:0] cellColour,      // Cell background colour
  input  wire logic [1:0] rowSize,         // Current row size
  output logic      [1:0] bankSelect,      // Current command bank
  output osdcd_mode_type  displayMode,     // Display mode
  output logic            hsyncPolarity,   // 1 active high
  output logic            vsyncPolarity,   // 1 active high
  output logic      [1:0] blinkFreq,       // Blink divider code
  output logic      [1:0] blinkDuty,       // Blink duty code
  output logic            blinkOn,         // Blink phase visible
  output logic      [5:0] horizontalStart, // Horizontal start
  output logic      [5:0] verticalStart,   // Vertical start
  output logic      [3:0] frameColour,     // Frame colour RGBI
  output logic            hstabEnable,     // Stabilization on
  output logic            halftoneActive,  // Half-tone in effect
  output logic      [1:0] firstRowSize,    // First row size
  output logic            firstCharStrobe, // First character start
  output logic            lineActive,      // Characters may show
  output logic            rowsActive,      // Below vertical start
  output logic            fbOut,           // Fast blanking
  output logic      [3:0] rgbiOut,         // Pixel colour
  output logic            portPinZero,     // Port pin 0
  output logic            portPinOne,      // Port pin 1
  output logic            sharedPortPin    // Port or monitor pin
);

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic [1:0] bank_q;
  logic [3:0] syncMode_q;
  logic [3:0] blink_q;
  logic       pinFunc_q;
  logic [5:0] vStart_q;
  logic [5:0] hStart_q;
  logic [2:0] portData_q;
  logic [3:0] frameCol_q;
  logic [3:0] misc_q;
  logic       inB0;
  logic       inB1;
  logic [3:0] hiNib;

  assign hiNib = cmdByte[7:4];
  assign inB0  = cmdValid && bank_q == `OSDCD_BANK_00;
  assign inB1  = cmdValid && bank_q == `OSDCD_BANK_01;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_q <= 2'h0;
    end else if (cmdValid && cmdByte[7:2] == `OSDCD_OP_BANK) begin
      bank_q <= cmdByte[1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncMode_q <= `OSDCD_RST_SYNC_MODE;
    end else if (inB1 && hiNib == `OSDCD_OP_SYNC_MODE) begin
      syncMode_q <= cmdByte[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_q <= `OSDCD_RST_BLINK;
    end else if (inB1 && hiNib == `OSDCD_OP_BLINK) begin
      blink_q <= cmdByte[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinFunc_q <= 1'b0;
    end else if (inB1 && hiNib == `OSDCD_OP_PINFUNC &&
                 cmdByte[3] == 1'b0 && cmdByte[1:0] == 2'h0) begin
      pinFunc_q <= cmdByte[`OSDCD_PINFUNC_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vStart_q <= 6'h00;
      hStart_q <= 6'h00;
    end else if (inB1) begin
      case (hiNib)
        `OSDCD_OP_VSTART: begin
          vStart_q[5:2] <= cmdByte[3:0];
        end
        `OSDCD_OP_VH_START: begin
          vStart_q[1:0] <= cmdByte[3:2];
          hStart_q[5:4] <= cmdByte[1:0];
        end
        `OSDCD_OP_HSTART: begin
          hStart_q[3:0] <= cmdByte[3:0];
        end
        default: begin
          hStart_q <= hStart_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      portData_q <= 3'h0;
    end else if (inB1 && cmdByte[7:6] == `OSDCD_OP_PORT) begin
      portData_q <= {cmdByte[`OSDCD_PORT_SHARED], cmdByte[1:0]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameCol_q <= `OSDCD_RST_FRAME_COL;
    end else if (inB0 && hiNib == `OSDCD_OP_FRAME_COL) begin
      frameCol_q <= cmdByte[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      misc_q <= `OSDCD_RST_MISC;
    end else if (inB0 && hiNib == `OSDCD_OP_MISC) begin
      misc_q <= cmdByte[3:0];
    end
  end

  assign bankSelect      = bank_q;
  assign hsyncPolarity   = syncMode_q[3];
  assign vsyncPolarity   = syncMode_q[2];
  assign displayMode     = osdcd_mode_type'(syncMode_q[1:0]);
  assign blinkFreq       = blink_q[3:2];
  assign blinkDuty       = blink_q[1:0];
  assign horizontalStart = hStart_q;
  assign verticalStart   = vStart_q;
  assign frameColour     = frameCol_q;
  assign hstabEnable     = misc_q[`OSDCD_HSTAB_BIT];
  assign firstRowSize    = misc_q[1:0];

  // ---------------------------------------------------------------
  // Sync inputs
  // ---------------------------------------------------------------
  logic [1:0] hsSync_q;
  logic [1:0] vsSync_q;
  logic       hsAct_q;
  logic       vsAct_q;
  logic       hsAct;
  logic       vsAct;
  logic       hsEdge;
  logic       vsEdge;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Idle level of the default active-low sync: no false edge
      hsSync_q <= 2'h3;
      vsSync_q <= 2'h3;
    end else begin
      hsSync_q <= {hsSync_q[0], hsyncPin};
      vsSync_q <= {vsSync_q[0], vsyncPin};
    end
  end

  assign hsAct = hsSync_q[1] ~^ hsyncPolarity;
  assign vsAct = vsSync_q[1] ~^ vsyncPolarity;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hsAct_q <= 1'b0;
      vsAct_q <= 1'b0;
    end else begin
      hsAct_q <= hsAct;
      vsAct_q <= vsAct;
    end
  end

  assign hsEdge = hsAct && !hsAct_q;
  assign vsEdge = vsAct && !vsAct_q;

  // ---------------------------------------------------------------
  // Horizontal start
  // ---------------------------------------------------------------
  osdcd_hstate_type hState_q;
  logic [8:0]       hCnt_q;
  logic [8:0]       hTarget;

  assign hTarget = 9'(`OSDCD_HSTART_MUL * hStart_q + `OSDCD_HSTART_ADD);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hState_q <= H_WAIT;
      hCnt_q   <= 9'h000;
    end else if (hsEdge) begin
      hState_q <= H_COUNT;
      hCnt_q   <= 9'h001;
    end else begin
      case (hState_q)
        H_WAIT: begin
          hCnt_q <= 9'h000;
        end
        H_COUNT: begin
          if (hCnt_q == hTarget) begin
            hState_q <= H_SHOW;
          end else begin
            hCnt_q <= hCnt_q + 9'h001;
          end
        end
        H_SHOW: begin
          hCnt_q <= hCnt_q;
        end
        default: begin
          hState_q <= H_WAIT;
        end
      endcase
    end
  end

  assign firstCharStrobe = hState_q == H_COUNT && hCnt_q == hTarget
                           && !hsEdge;
  assign lineActive      = hState_q == H_SHOW;

  // ---------------------------------------------------------------
  // Vertical start
  // ---------------------------------------------------------------
  logic [8:0] lineCnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lineCnt_q <= 9'h000;
    end else if (vsEdge) begin
      lineCnt_q <= 9'h000;
    end else if (hsEdge && lineCnt_q != 9'h1ff) begin
      lineCnt_q <= lineCnt_q + 9'h001;
    end
  end

  assign rowsActive = lineCnt_q >= 9'(`OSDCD_VSTART_MUL * vStart_q);

  // ---------------------------------------------------------------
  // Blink
  // ---------------------------------------------------------------
  logic [6:0] frameCnt_q;
  logic [7:0] period;
  logic [6:0] phase;
  logic [7:0] onLen;
  logic       blink_q2;

  assign period = 8'(`OSDCD_BLINK_BASE) << blinkFreq;
  assign phase  = frameCnt_q & 7'(period - 8'h01);

  always_comb begin
    case (blinkDuty)
      2'h0:    onLen = period - (period >> 2);
      2'h1:    onLen = period >> 1;
      2'h2:    onLen = period >> 2;
      default: onLen = period >> 1;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameCnt_q <= 7'h00;
    end else if (vsEdge) begin
      frameCnt_q <= frameCnt_q + 7'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_q2 <= 1'b1;
    end else begin
      blink_q2 <= {1'b0, phase} < onLen;
    end
  end

  assign blinkOn = blink_q2;

  // ---------------------------------------------------------------
  // Pixel composition
  // ---------------------------------------------------------------
  logic       fb_d;
  logic [3:0] rgbi_d;
  logic       shadowOk;
  logic       fb_q;
  logic [3:0] rgbi_q;

  // Shadow only for 2x and 4x
  assign shadowOk = rowSize == 2'h1 || rowSize == 2'h3;

  always_comb begin
    fb_d   = charDot;
    rgbi_d = fgColour;
    case (displayMode)
      MODE_PLAIN: begin
        fb_d = charDot;
      end
      MODE_NWSHAD: begin
        fb_d = charDot || (shadowOk && shadowDot);
        if (!charDot) rgbi_d = cellColour;
      end
      MODE_BOX: begin
        fb_d = charDot || inCell;
        if (!charDot) rgbi_d = cellColour;
      end
      MODE_FRAME: begin
        fb_d = 1'b1;
        if (!charDot) rgbi_d = frameCol_q;
      end
      default: begin
        fb_d = charDot;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fb_q   <= 1'b0;
      rgbi_q <= 4'h0;
    end else begin
      fb_q   <= fb_d;
      rgbi_q <= rgbi_d;
    end
  end

  assign fbOut   = fb_q;
  assign rgbiOut = rgbi_q;

  assign halftoneActive = misc_q[`OSDCD_HTONE_BIT] && acmBit;

  assign sharedPortPin = pinFunc_q ? acmBit : portData_q[2];
  assign portPinOne    = portData_q[1];
  assign portPinZero   = portData_q[0];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_bank_load: assert property (
    cmdValid && cmdByte[7:2] == 6'h1e |=> bankSelect == $past(cmdByte[1:0])
  ) else $error("bank flags not loaded");
  a_mode_load: assert property (
    inB1 && hiNib == 4'h5 |=> displayMode == $past(cmdByte[1:0])
      && hsyncPolarity == $past(cmdByte[3])
  ) else $error("sync and mode not loaded");
  a_blink_load: assert property (
    inB1 && hiNib == 4'h6 |=> blinkFreq == $past(cmdByte[3:2])
  ) else $error("blink not loaded");
  a_wrong_bank: assert property (
    cmdValid && bank_q == 2'h2 |=> $stable(syncMode_q) && $stable(misc_q)
      && $stable(frameCol_q) && $stable(blink_q)
  ) else $error("unmatched byte changed state");
  a_hstart_time: assert property (
    hsEdge ##1 (!hsEdge && hState_q == H_COUNT) [*5] |-> hCnt_q == 9'h005
  ) else $error("horizontal count wrong");
  a_frame_fill: assert property (
    displayMode == MODE_FRAME && !charDot |=> fbOut
      && rgbiOut == $past(frameColour)
  ) else $error("frame fill wrong");
  a_shared_pin: assert property (
    !pinFunc_q |-> sharedPortPin == portData_q[2]
  ) else $error("shared pin not port");
  a_halftone_gate: assert property (
    !acmBit |-> !halftoneActive
  ) else $error("half-tone without monitor");
  a_port_write: assert property (
    inB1 && cmdByte[7:6] == 2'h3 |=> portPinZero == $past(cmdByte[0])
      && portPinOne == $past(cmdByte[1])
  ) else $error("port write lost");

  c_strobe: cover property (firstCharStrobe);
  c_frame: cover property (displayMode == MODE_FRAME ##1 fbOut);
  c_blink: cover property (blinkOn ##1 !blinkOn);

endmodule : osdcd_decoder

`default_nettype wire

// File: tb/osdcd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module osdcd_host_model (
  input  wire logic       clk,      // Display clock
  output logic      [7:0] cmdByte,  // Command byte to the decoder
  output logic            cmdValid  // Byte strobe
);

  initial begin
    cmdByte  = 8'h00;
    cmdValid = 1'b0;
  end

  // ----------------------------------------------------------------
  // Command byte transfer
  // ----------------------------------------------------------------
  // host ordering duties
  // Callers pick the bank first, set both starts after reset, keep H >= 4
  task automatic send(input logic [7:0] q[$], input int gap);
    @(posedge clk);
    foreach (q[i]) begin
      if (q[i][7:4] == 4'h6 && q[i][1:0] == 2'h3)
        continue;
      cmdByte  <= q[i];
      cmdValid <= 1'b1;
      @(posedge clk);
      if (gap > 0) begin
        cmdValid <= 1'b0;
        cmdByte  <= ~cmdByte;
        repeat (gap) @(posedge clk);
      end
    end
    // Released byte lines show the last byte inverted for gap 0, but the last byte itself again after a gap
    cmdValid <= 1'b0;
    cmdByte  <= ~cmdByte;
    @(posedge clk);
    #1;
  endtask : send

endmodule : osdcd_host_model

`default_nettype wire

// File: tb/test_osdcd_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module test_osdcd_decoder
  import osdcd_pkg::*;
;
  logic           clk, rst, cmdValid, hsyncPin, vsyncPin;
  logic           charDot, shadowDot, inCell, acmBit;
  logic     [7:0] cmdByte, b;
  logic     [3:0] fgColour, cellColour, frameColour, rgbiOut;
  logic     [1:0] rowSize, bankSelect, blinkFreq, blinkDuty, firstRowSize;
  osdcd_mode_type displayMode;
  logic     [5:0] horizontalStart, verticalStart;
  logic           hsyncPolarity, vsyncPolarity, blinkOn, hstabEnable;
  logic           halftoneActive, firstCharStrobe, lineActive, rowsActive;
  logic           fbOut, portPinZero, portPinOne, sharedPortPin;
  int             miscompares, nChecks, n4, n9, ons, per;
  logic     [7:0] blinkCodes[5] = '{8'h60, 8'h65, 8'h62, 8'h6c, 8'h69};

  osdcd_host_model i_osdcd_host_model (
    .clk(clk), .cmdByte(cmdByte), .cmdValid(cmdValid)
  );

  osdcd_decoder i_osdcd_decoder (
    .clk(clk), .rst(rst), .cmdByte(cmdByte), .cmdValid(cmdValid),
    .hsyncPin(hsyncPin), .vsyncPin(vsyncPin), .charDot(charDot),
    .shadowDot(shadowDot), .inCell(inCell), .acmBit(acmBit),
    .fgColour(fgColour), .cellColour(cellColour), .rowSize(rowSize),
    .bankSelect(bankSelect), .displayMode(displayMode),
    .hsyncPolarity(hsyncPolarity), .vsyncPolarity(vsyncPolarity),
    .blinkFreq(blinkFreq), .blinkDuty(blinkDuty), .blinkOn(blinkOn),
    .horizontalStart(horizontalStart), .verticalStart(verticalStart),
    .frameColour(frameColour), .hstabEnable(hstabEnable),
    .halftoneActive(halftoneActive), .firstRowSize(firstRowSize),
    .firstCharStrobe(firstCharStrobe), .lineActive(lineActive),
    .rowsActive(rowsActive), .fbOut(fbOut), .rgbiOut(rgbiOut),
    .portPinZero(portPinZero), .portPinOne(portPinOne),
    .sharedPortPin(sharedPortPin)
  );

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // Active-low sync pulses; counts visible blink phases seen after each
  task automatic pulse(input logic vert, input int n);
    repeat (n) begin
      @(posedge clk);
      if (vert)
        vsyncPin <= 1'b0;
      else
        hsyncPin <= 1'b0;
      repeat (2) @(posedge clk);
      vsyncPin <= 1'b1;
      hsyncPin <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      if (blinkOn === 1'b1)
        ons++;
    end
  endtask : pulse

  // Cycles from the hsync pin edge to the first character strobe
  task automatic measure(output int n);
    n = 0;
    @(posedge clk);
    hsyncPin <= 1'b0;
    while (firstCharStrobe !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400) begin
        miscompares++;
        tally_and_finish;
      end
    end
    @(posedge clk);
    hsyncPin <= 1'b1;
    #1;
    chk(lineActive, 1'b1);
  endtask : measure

  task automatic pix(input logic [3:0] c, input logic [1:0] sz);
    @(posedge clk);
    {charDot, shadowDot, inCell, acmBit} <= c;
    rowSize <= sz;
    repeat (2) @(posedge clk);
    #1;
  endtask : pix

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hsyncPin = 1'b1;
    vsyncPin = 1'b1;
    {charDot, shadowDot, inCell, acmBit} = 4'h1;
    fgColour = 4'h9;
    cellColour = 4'h6;
    rowSize = 2'h0;
    miscompares = 0;
    nChecks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(bankSelect, 2'h0);
    chk({hsyncPolarity, vsyncPolarity}, 2'h0);
    chk({blinkFreq, blinkDuty}, 4'h0);
    chk(frameColour, 4'h2);
    chk({hstabEnable, halftoneActive}, 2'h0);
    chk(firstRowSize, 2'h0);
    chk(sharedPortPin, 1'b0);
    // Back-to-back bank 01 burst
    i_osdcd_host_model.send({8'h79, 8'h5e, 8'h66, 8'h9f, 8'ha9, 8'hb5,
                             8'hd3}, 0);
    chk(bankSelect, 2'h1);
    chk({hsyncPolarity, vsyncPolarity, displayMode}, 4'he);
    chk({blinkFreq, blinkDuty}, 4'h6);
    chk(verticalStart, 6'h3e);
    chk(horizontalStart, 6'h15);
    chk({sharedPortPin, portPinOne, portPinZero}, 3'h7);
    i_osdcd_host_model.send({8'hef, 8'h74}, 2);
    chk({sharedPortPin, portPinOne, portPinZero}, 3'h7);
    i_osdcd_host_model.send({8'h70}, 0);
    chk(sharedPortPin, 1'b0);
    for (int m = 0; m < 4; m++) begin
      i_osdcd_host_model.send({8'h50 | m[7:0]}, 0);
      chk(displayMode, m[7:0]);
      pix(4'h6, 2'h1);
      chk(fbOut, m != 0);
      if (m == 1 || m == 2)
        chk(rgbiOut, 4'h6);
    end
    pix(4'h0, 2'h0);
    chk({fbOut, rgbiOut}, 5'h12);
    i_osdcd_host_model.send({8'h51}, 0);
    pix(4'h6, 2'h2);
    chk(fbOut, 1'b0);
    i_osdcd_host_model.send({8'h52}, 0);
    pix(4'h0, 2'h0);
    chk(fbOut, 1'b0);
    i_osdcd_host_model.send({8'h50}, 0);
    pix(4'h8, 2'h0);
    chk({fbOut, rgbiOut}, 5'h19);
    // Blink period and visible share over one full period
    foreach (blinkCodes[i]) begin
      b = blinkCodes[i];
      i_osdcd_host_model.send({b}, 0);
      per = 16 << b[3:2];
      ons = 0;
      pulse(1'b1, per);
      chk({blinkFreq, blinkDuty}, b[3:0]);
      chk(ons[7:0], b[1:0] == 0 ? per * 3 / 4 : per >> b[1:0]);
    end
    i_osdcd_host_model.send({8'h90, 8'ha5}, 0);
    chk(verticalStart, 6'h01);
    chk(horizontalStart, 6'h15);
    pulse(1'b1, 1);
    pulse(1'b0, 3);
    chk(rowsActive, 1'b0);
    pulse(1'b0, 2);
    chk(rowsActive, 1'b1);
    i_osdcd_host_model.send({8'ha4, 8'hb4}, 0);
    measure(n4);
    i_osdcd_host_model.send({8'hb9}, 0);
    measure(n9);
    chk(n9 - n4, 8'h14);
    chk(n4 >= 22 && n4 <= 26, 1'b1);
    // Bank 00 commands, then a bank-01 pattern that must be ignored
    i_osdcd_host_model.send({8'h78, 8'h4a, 8'h66}, 0);
    chk(bankSelect, 2'h0);
    chk(frameColour, 4'ha);
    chk(blinkDuty, 2'h1);
    for (int s = 0; s < 4; s++) begin
      i_osdcd_host_model.send({8'h5c | s[7:0]}, 0);
      chk({hstabEnable, firstRowSize}, {1'b1, s[1:0]});
    end
    chk(displayMode, 2'h0);
    pix(4'h1, 2'h0);
    chk(halftoneActive, 1'b1);
    pix(4'h0, 2'h0);
    chk(halftoneActive, 1'b0);
    // Bank 10 accepts only the bank command
    i_osdcd_host_model.send({8'h7a, 8'h4f, 8'h53, 8'hff, 8'h9f, 8'h79}, 0);
    chk(frameColour, 4'ha);
    chk({hstabEnable, displayMode}, 3'h4);
    chk(verticalStart, 6'h01);
    chk({portPinOne, portPinZero}, 2'h3);
    chk(bankSelect, 2'h1);
    tally_and_finish;
  end

endmodule : test_osdcd_decoder

`default_nettype wire
